/* common/instr_exec_pkg.sv */
// constants for the or/move/return instruction executor
package instr_exec_pkg;
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int PC_W = 13;
	localparam logic [INSTR_W-1:0] OPC_RETFI = 14'h0009;
	localparam logic [INSTR_W-1:0] NOP_MASK = 14'h3f9f;
	localparam logic [INSTR_W-1:0] NOP_VAL = 14'h0000;
	localparam logic [INSTR_W-1:0] STORE_MASK = 14'h3f80;
	localparam logic [INSTR_W-1:0] STORE_VAL = 14'h0080;
	localparam logic [INSTR_W-1:0] ORF_MASK = 14'h3f00;
	localparam logic [INSTR_W-1:0] ORF_VAL = 14'h0400;
	localparam logic [INSTR_W-1:0] ORL_MASK = 14'h3f00;
	localparam logic [INSTR_W-1:0] ORL_VAL = 14'h3800;
	localparam logic [INSTR_W-1:0] RETL_MASK = 14'h3c00;
	localparam logic [INSTR_W-1:0] RETL_VAL = 14'h3400;
	localparam int DEST_BIT = 7;
	localparam int INT_ENABLE_BIT = 7;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam int INSTR_CLK_DIV = 4;
	localparam logic [1:0] DIV_LAST = 2'(INSTR_CLK_DIV - 1);
	typedef enum logic [2:0] {OP_NOP, OP_ORL, OP_ORF, OP_STORE, OP_RETFI, OP_RETL,
		OP_OTHER} op_e;
endpackage

/* common/decode_if.sv */
// decoded instruction handed from the decoder to the executor
`timescale 1ns/1ps
interface decode_if;
	import instr_exec_pkg::*;
	op_e op;
	logic [DATA_W-1:0] literal;
	logic [ADDR_W-1:0] faddr;
	logic dest_file;
	modport dec (output op, literal, faddr, dest_file);
	modport exe (input op, literal, faddr, dest_file);
endinterface

/* core/instr_decoder.sv */
// registered decoder for the supported opcodes
`timescale 1ns/1ps
module instr_decoder
	import instr_exec_pkg::*;
(
	input wire logic clk_i, // core clock
	input wire logic rst_n_i, // sync reset
	input wire logic load_i, // latch a new word
	input wire logic [INSTR_W-1:0] word_i, // fetched word
	decode_if.dec dec // decoded result
);
	op_e next_op;
	always_comb begin
		if ((word_i & NOP_MASK) == NOP_VAL) next_op = OP_NOP;
		else if (word_i == OPC_RETFI) next_op = OP_RETFI;
		else if ((word_i & STORE_MASK) == STORE_VAL) next_op = OP_STORE;
		else if ((word_i & ORF_MASK) == ORF_VAL) next_op = OP_ORF;
		else if ((word_i & ORL_MASK) == ORL_VAL) next_op = OP_ORL;
		else if ((word_i & RETL_MASK) == RETL_VAL) next_op = OP_RETL;
		else next_op = OP_OTHER;
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			dec.op <= OP_NOP;
			dec.literal <= '0;
			dec.faddr <= '0;
			dec.dest_file <= 1'b0;
		end else if (load_i) begin
			dec.op <= next_op;
			dec.literal <= word_i[DATA_W-1:0];
			dec.faddr <= word_i[ADDR_W-1:0];
			dec.dest_file <= word_i[DEST_BIT];
		end
	end
endmodule // instr_decoder

/* core/or_move_return_instr_exec.sv */
// executor for or, store and return instructions
// How it works
// - or literal into accumulator, write back, zero flag from result
// - or accumulator with addressed file register, zero flag from result
// - destination bit 0 writes accumulator, 1 writes the file register
// - return from interrupt sets global interrupt enable, control bit 7
// - fixed return-from-interrupt opcode pops stack into pc, two cycles, no flags
// - return with literal loads low opcode byte into accumulator
// - return with literal pops stack into pc, two cycles, no flags
`timescale 1ns/1ps
module or_move_return_instr_exec
	import instr_exec_pkg::*;
(
	input wire logic CORE_CLK_I, // core clock
	input wire logic RST_N_I, // sync reset, active low
	input wire logic [INSTR_W-1:0] PROG_WORD_I, // word at PROG_ADDR_O
	input wire logic [DATA_W-1:0] FILE_RDATA_I, // data of FILE_ADDR_O
	input wire logic [PC_W-1:0] STACK_TOP_ENTRY_I, // stack top entry
	output logic [PC_W-1:0] PROG_ADDR_O, // program counter
	output logic [ADDR_W-1:0] FILE_ADDR_O, // file register address
	output logic [DATA_W-1:0] FILE_WDATA_O, // file write data
	output logic FILE_WE_O, // file write strobe, one core clock
	output logic STACK_POP_O, // stack pop strobe, one core clock
	output logic [DATA_W-1:0] ACCUMULATOR_O, // working register
	output logic ZERO_FLAG_O, // zero flag
	output logic INT_ENABLE_SET_O, // pulse: set interrupt_control_register bit
	output logic GLOBAL_INTERRUPT_ENABLE_FLAG_O, // local copy of enable flag
	output logic BUSY_O // second cycle of a two-cycle instruction, registered one core clock late
);
	decode_if dif ();
	logic [1:0] div_cnt;
	logic cycle_en;
	logic second;
	logic load;
	logic [DATA_W-1:0] or_result;
	logic executing;
	logic ex_now;
	logic ret_now;

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) div_cnt <= '0;
		else if (div_cnt == DIV_LAST) div_cnt <= '0;
		else div_cnt <= div_cnt + 2'd1;
	end
	assign cycle_en = (div_cnt == DIV_LAST);
	assign ex_now = cycle_en && executing && !second;
	assign ret_now = ex_now && (dif.op == OP_RETFI || dif.op == OP_RETL);
	// a return fetches from the popped address in its second cycle, so the word
	// prefetched behind the return is dropped instead of executed
	assign load = cycle_en && !ret_now;

	instr_decoder u_dec (
		.clk_i(CORE_CLK_I),
		.rst_n_i(RST_N_I),
		.load_i(load),
		.word_i(PROG_WORD_I),
		.dec(dif.dec)
	);

	// decoded word is valid from the first cycle_en after reset onward
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) executing <= 1'b0;
		else if (load) executing <= 1'b1;
	end

	assign or_result = ACCUMULATOR_O | (dif.op == OP_ORL ? dif.literal : FILE_RDATA_I);

	// two-cycle returns hold a second instruction cycle
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) second <= 1'b0;
		else if (cycle_en) second <= !second && executing &&
			(dif.op == OP_RETFI || dif.op == OP_RETL);
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) BUSY_O <= 1'b0;
		else BUSY_O <= second;
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) PROG_ADDR_O <= PC_RESET;
		else if (cycle_en && executing && !second &&
			(dif.op == OP_RETFI || dif.op == OP_RETL))
			PROG_ADDR_O <= STACK_TOP_ENTRY_I;
		else if (load) PROG_ADDR_O <= PROG_ADDR_O + 13'd1;
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) STACK_POP_O <= 1'b0;
		else STACK_POP_O <= cycle_en && executing && !second &&
			(dif.op == OP_RETFI || dif.op == OP_RETL);
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) FILE_ADDR_O <= '0;
		else FILE_ADDR_O <= dif.faddr;
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			FILE_WE_O <= 1'b0;
			FILE_WDATA_O <= '0;
		end else begin
			FILE_WE_O <= 1'b0;
			if (cycle_en && executing && !second) begin
				if (dif.op == OP_STORE) begin
					FILE_WE_O <= 1'b1;
					FILE_WDATA_O <= ACCUMULATOR_O;
				end else if (dif.op == OP_ORF && dif.dest_file) begin
					FILE_WE_O <= 1'b1;
					FILE_WDATA_O <= or_result;
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) ACCUMULATOR_O <= ACC_RESET;
		else if (cycle_en && executing && !second) begin
			if (dif.op == OP_ORL) ACCUMULATOR_O <= or_result;
			else if (dif.op == OP_ORF && !dif.dest_file) ACCUMULATOR_O <= or_result;
			else if (dif.op == OP_RETL) ACCUMULATOR_O <= dif.literal;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) ZERO_FLAG_O <= 1'b0;
		else if (cycle_en && executing && !second &&
			(dif.op == OP_ORL || dif.op == OP_ORF))
			ZERO_FLAG_O <= (or_result == '0);
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			INT_ENABLE_SET_O <= 1'b0;
			GLOBAL_INTERRUPT_ENABLE_FLAG_O <= 1'b0;
		end else begin
			INT_ENABLE_SET_O <= cycle_en && executing && !second && dif.op == OP_RETFI;
			if (cycle_en && executing && !second && dif.op == OP_RETFI)
				GLOBAL_INTERRUPT_ENABLE_FLAG_O <= 1'b1;
		end
	end

	property p_orl_acc;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ex_now && dif.op == OP_ORL |=> ACCUMULATOR_O == ($past(ACCUMULATOR_O) | $past(dif.literal));
	endproperty
	a_orl_acc: assert property (p_orl_acc) else $error("or literal result wrong");
	property p_orl_zero;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ex_now && dif.op == OP_ORL |=>
			ZERO_FLAG_O == (($past(ACCUMULATOR_O) | $past(dif.literal)) == 8'h00);
	endproperty
	a_orl_zero: assert property (p_orl_zero) else $error("literal zero flag wrong");
	property p_store;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ex_now && dif.op == OP_STORE |=> FILE_WE_O && FILE_WDATA_O == $past(ACCUMULATOR_O)
			&& $stable(ZERO_FLAG_O);
	endproperty
	a_store: assert property (p_store) else $error("store to file wrong");
	property p_orf_zero;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ex_now && dif.op == OP_ORF |=>
			ZERO_FLAG_O == (($past(ACCUMULATOR_O) | $past(FILE_RDATA_I)) == 8'h00);
	endproperty
	a_orf_zero: assert property (p_orf_zero) else $error("zero flag wrong");
	property p_orf_dest;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ex_now && dif.op == OP_ORF |=> FILE_WE_O == $past(dif.dest_file);
	endproperty
	a_orf_dest: assert property (p_orf_dest) else $error("destination select wrong");
	property p_orf_to_acc;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ex_now && dif.op == OP_ORF && !dif.dest_file |=>
			ACCUMULATOR_O == ($past(ACCUMULATOR_O) | $past(FILE_RDATA_I)) && !FILE_WE_O;
	endproperty
	a_orf_to_acc: assert property (p_orf_to_acc) else $error("or to acc wrong");
	property p_orf_to_file;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ex_now && dif.op == OP_ORF && dif.dest_file |=>
			FILE_WDATA_O == ($past(ACCUMULATOR_O) | $past(FILE_RDATA_I))
			&& $stable(ACCUMULATOR_O);
	endproperty
	a_orf_to_file: assert property (p_orf_to_file) else $error("or to file wrong");
	property p_int_enable;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ex_now && dif.op == OP_RETFI |=> INT_ENABLE_SET_O ##1 GLOBAL_INTERRUPT_ENABLE_FLAG_O;
	endproperty
	a_int_enable: assert property (p_int_enable) else $error("enable flag not set");
	sequence s_two_cycles;
		second [*4] ##1 !second;
	endsequence
	property p_retfi;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ex_now && dif.op == OP_RETFI |=> (STACK_POP_O and s_two_cycles);
	endproperty
	a_retfi: assert property (p_retfi) else $error("return from interrupt timing wrong");
	property p_retfi_pc;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ex_now && dif.op == OP_RETFI |=> PROG_ADDR_O == $past(STACK_TOP_ENTRY_I)
			&& $stable(ZERO_FLAG_O) && $stable(ACCUMULATOR_O);
	endproperty
	a_retfi_pc: assert property (p_retfi_pc) else $error("return pc wrong");
	property p_retl_acc;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ex_now && dif.op == OP_RETL |=> ACCUMULATOR_O == $past(dif.literal);
	endproperty
	a_retl_acc: assert property (p_retl_acc) else $error("literal not loaded");
	property p_retl_pc;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ex_now && dif.op == OP_RETL |=> ((PROG_ADDR_O == $past(STACK_TOP_ENTRY_I)
			&& $stable(ZERO_FLAG_O)) and s_two_cycles);
	endproperty
	a_retl_pc: assert property (p_retl_pc) else $error("return address wrong");
	property p_nop;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ex_now && dif.op == OP_NOP |=> $stable(ACCUMULATOR_O) && !FILE_WE_O && !STACK_POP_O
			&& !second && PROG_ADDR_O == $past(PROG_ADDR_O) + 13'd1;
	endproperty
	a_nop: assert property (p_nop) else $error("nop changed state");
	property p_ret_refetch;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ret_now |-> ##4 (load && PROG_ADDR_O == $past(STACK_TOP_ENTRY_I, 4));
	endproperty
	a_ret_refetch: assert property (p_ret_refetch) else $error("return fetch wrong");
	sequence s_busy_window;
		BUSY_O [*4] ##1 !BUSY_O;
	endsequence
	property p_busy;
		@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ret_now |=> ##1 s_busy_window;
	endproperty
	a_busy: assert property (p_busy) else $error("second cycle flag wrong");
endmodule // or_move_return_instr_exec

/* verification/prog_memory_model.sv */
// program memory model answering the fetch address with a word
`timescale 1ns/1ps
module prog_memory_model
	import instr_exec_pkg::*;
(
	input wire logic [PC_W-1:0] addr_i, // fetch address
	output logic [INSTR_W-1:0] word_o // word at that address
);
	logic [INSTR_W-1:0] mem [0:(1<<PC_W)-1];
	initial begin
		for (int i = 0; i < (1<<PC_W); i++) mem[i] = '0;
	end
	assign word_o = mem[addr_i];
endmodule // prog_memory_model

/* verification/or_move_return_instr_exec_bench.sv */
// self-checking bench for the or, store and return executor
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin err_total++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module or_move_return_instr_exec_bench;
	import instr_exec_pkg::*;
	logic clk = 0, rst_n = 0;
	logic [PC_W-1:0] top = '0, pc;
	logic [INSTR_W-1:0] word;
	logic [DATA_W-1:0] rdata, wd, acc, fwd;
	logic [ADDR_W-1:0] wa, fa;
	logic [DATA_W-1:0] freg [0:127];
	logic we, pop, z, gset, gflag, busy;
	int wn, pn, gn, err_total, checked, cycles;
	always #5 clk = ~clk;
	assign rdata = freg[fa];
	or_move_return_instr_exec DUT (.CORE_CLK_I(clk), .RST_N_I(rst_n), .PROG_WORD_I(word),
		.FILE_RDATA_I(rdata), .STACK_TOP_ENTRY_I(top), .PROG_ADDR_O(pc), .FILE_ADDR_O(fa),
		.FILE_WDATA_O(fwd), .FILE_WE_O(we), .STACK_POP_O(pop), .ACCUMULATOR_O(acc),
		.ZERO_FLAG_O(z), .INT_ENABLE_SET_O(gset), .GLOBAL_INTERRUPT_ENABLE_FLAG_O(gflag),
		.BUSY_O(busy));
	prog_memory_model PM (.addr_i(pc), .word_o(word));
	// file register model and strobe counters
	always @(posedge clk) begin
		cycles++;
		if (we === 1'b1) begin
			wn++;
			wa = fa;
			wd = fwd;
			freg[fa] <= fwd;
		end
		if (pop === 1'b1) pn++;
		if (gset === 1'b1) gn++;
		if (cycles == 1000) begin
			err_total++;
			close_out;
		end
	end
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task rst;
		for (int i = 0; i < (1<<PC_W); i++) PM.mem[i] = '0;
		rst_n = 0;
		cyc(5);
		wn = 0;
		pn = 0;
		gn = 0;
		rst_n = 1;
	endtask
	task t_orl;
		rst;
		PM.mem[0] = 14'h3800;
		PM.mem[1] = 14'h38a0;
		PM.mem[2] = 14'h3805;
		cyc(9);
		`CHK("acc", 8'h00, acc)
		`CHK("zero", 1'b1, z)
		cyc(8);
		`CHK("acc", 8'ha5, acc)
		`CHK("zero", 1'b0, z)
		$display("or literal test done");
	endtask
	task t_file;
		rst;
		PM.mem[0] = 14'h3800;
		PM.mem[1] = 14'h00ff;
		PM.mem[2] = 14'h383c;
		PM.mem[3] = 14'h0421;
		PM.mem[4] = 14'h04a2;
		cyc(13);
		`CHK("writes", 1, wn)
		`CHK("waddr", 7'h7f, wa)
		`CHK("wdata", 8'h00, wd)
		`CHK("zero", 1'b1, z)
		cyc(8);
		`CHK("acc", 8'h7d, acc)
		`CHK("zero", 1'b0, z)
		`CHK("writes", 1, wn)
		cyc(4);
		`CHK("writes", 2, wn)
		`CHK("waddr", 7'h22, wa)
		`CHK("wdata", 8'hff, wd)
		`CHK("acc", 8'h7d, acc)
		$display("file register test done");
	endtask
	task t_retl;
		top = 13'h0123;
		rst;
		PM.mem[0] = 14'h3800;
		PM.mem[1] = 14'h375a;
		PM.mem[13'h123] = 14'h0060;
		cyc(13);
		`CHK("pc", 13'h0123, pc)
		`CHK("acc", 8'h5a, acc)
		`CHK("pops", 1, pn)
		`CHK("busy", 1'b1, busy)
		cyc(4);
		`CHK("pc", 13'h0124, pc)
		`CHK("busy", 1'b0, busy)
		cyc(4);
		`CHK("pc", 13'h0125, pc)
		`CHK("acc", 8'h5a, acc)
		`CHK("zero", 1'b1, z)
		`CHK("pops", 1, pn)
		`CHK("writes", 0, wn)
		$display("return with literal test done");
	endtask
	task t_ret_int;
		top = 13'h0040;
		rst;
		PM.mem[0] = 14'h3800;
		PM.mem[1] = 14'h0009;
		cyc(9);
		`CHK("enable flag", 1'b0, gflag)
		cyc(4);
		`CHK("pc", 13'h0040, pc)
		`CHK("enable set", 1, gn)
		`CHK("enable flag", 1'b1, gflag)
		`CHK("pops", 1, pn)
		`CHK("busy", 1'b1, busy)
		cyc(4);
		`CHK("pc", 13'h0041, pc)
		`CHK("zero", 1'b1, z)
		`CHK("busy", 1'b0, busy)
		$display("return from interrupt test done");
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 128; i++) freg[i] = 8'h00;
		freg[33] = 8'h41;
		freg[34] = 8'h82;
		@(negedge clk);
		t_orl;
		t_file;
		t_retl;
		t_ret_int;
		close_out;
	end
endmodule // or_move_return_instr_exec_bench
